// [design/dmc_pkg.sv]
package dmc_pkg;

    localparam int          NUM_CH       = 4;
    localparam int          ADDR_W       = 8;
    localparam int          FMT_W        = 64;
    localparam int          FIFO_DEPTH   = 4;

    localparam logic [7:0]  OFF_CTRL0    = 8'h00;
    localparam logic [7:0]  OFF_STRIDE   = 8'h04;
    localparam logic [7:0]  OFF_GLOBAL   = 8'h10;
    localparam logic [7:0]  OFF_STATUS   = 8'h14;

    localparam int          BUS_MODE_BIT = 7;
    localparam int          SIZE_HI      = 6;
    localparam int          SIZE_LO      = 4;
    localparam int          SRC_HI       = 3;
    localparam int          SRC_LO       = 0;
    localparam int          ODM_BIT      = 15;
    localparam int          REV_BIT      = 0;
    localparam int          FMT_DIR_BIT  = 60;
    localparam int          FMT_MD_HI    = 57;
    localparam int          FMT_MD_LO    = 56;

    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic        ODM_RST      = 1'b0;

    localparam logic [3:0]  SRC_EXT      = 4'h2;
    localparam logic [3:0]  SRC_TMR_EE   = 4'hC;
    localparam logic [3:0]  SRC_TMR_EP   = 4'hD;
    localparam logic [3:0]  SRC_TMR_PE   = 4'hE;

    localparam logic [2:0]  SZ_QUAD      = 3'h0;
    localparam logic [2:0]  SZ_BYTE      = 3'h1;
    localparam logic [2:0]  SZ_WORD      = 3'h2;
    localparam logic [2:0]  SZ_LONG      = 3'h3;
    localparam logic [2:0]  SZ_BLOCK     = 3'h4;

    localparam logic [1:0]  AM_DUAL      = 2'h0;
    localparam logic [1:0]  AM_SINGLE    = 2'h1;

    typedef enum logic [1:0] {KIND_EXT, KIND_TMR, KIND_FMT} dmc_kind_t;
    typedef enum logic [1:0] {ROUTE_EXT_EXT, ROUTE_EXT_PERIPH, ROUTE_PERIPH_EXT,
                              ROUTE_FORMAT} dmc_route_t;

    typedef struct packed {
        logic [1:0]  chan;
        dmc_kind_t   kind;
        dmc_route_t  route;
        logic        dir;
        logic [1:0]  addr_mode;
        logic        bus_burst;
        logic [2:0]  size_code;
        logic [5:0]  access_bytes;
    } dmc_desc_t;

endpackage

// [design/dmc_channel_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// RULE1 - external request source honoured only on channels zero and one
// RULE2 - channels two and three ignore external requests in normal mode
// RULE3 - later revision accepts external source on all four channels; code takes two and three only in on-demand mode, where zero ignores them
// RULE4 - original revision: channel zero format transfers are single address only
// RULE5 - on-demand channel zero: direction bit 60, address mode bits 57-56
// RULE6 - bus-mode bit 7: 0 cycle steal (reset), 1 burst
// RULE7 - size field bits 6..4 fixes transfer width and external access size
// RULE8 - register source or destination accessed at the size field width
// RULE9 - timer capture requests: ext-ext, ext-periph, periph-ext, all dual address
// RULE10 - size codes: 000 64-bit, 001 8, 010 16, 011 32, 100 32-byte block
// RULE11 - software never programs prohibited source codes; behaviour undefined

module dmc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [WIDTH-1:0]  in_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [WIDTH-1:0]       out_data
);
    localparam int PW = $clog2(DEPTH);

    // pointers wrap by overflow, so only powers of two are served
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("dmc_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [PW:0]                 count;
    } dmc_fifo_state_t;

    dmc_fifo_state_t s_reg;
    dmc_fifo_state_t s_next;
    logic            push;
    logic            pop;

    assign in_ready  = (s_reg.count != (PW+1)'(DEPTH));
    assign out_valid = (s_reg.count != '0);
    assign out_data  = s_reg.mem[s_reg.rptr];

    always_comb begin
        s_next = s_reg;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        if (push) begin
            s_next.mem[s_reg.wptr] = in_data;
            s_next.wptr            = s_reg.wptr + 1'b1;
        end
        if (pop) begin
            s_next.rptr = s_reg.rptr + 1'b1;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // dmc_fifo

module dmc_channel_ctrl
    import dmc_pkg::*;
#(
    parameter bit LATER_REV = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    input  wire logic [NUM_CH-1:0] ext_req_n,
    input  wire logic              timer_unit_capture,
    input  wire logic [NUM_CH-1:0] chan_enable,
    input  wire logic              global_enable,
    input  wire logic              fmt_valid,
    output logic                   fmt_ready,
    input  wire logic [FMT_W-1:0]  fmt_data,
    output logic                   start_valid,
    input  wire logic              start_ready,
    output dmc_desc_t              start_desc
);
    typedef struct packed {
        logic [NUM_CH-1:0][7:0] ctrl;
        logic                   on_demand_transfer_mode;
        logic [NUM_CH-1:0]      ext_q1;
        logic [NUM_CH-1:0]      ext_q2;
        logic [NUM_CH-1:0]      ext_q3;
        logic [NUM_CH-1:0]      pend_ext;
        logic [NUM_CH-1:0]      pend_tmr;
        logic                   start_valid;
        dmc_desc_t              desc;
        logic [31:0]            rdata;
    } dmc_state_t;

    // two-bit channel index and four-bit status fields assume four channels
    if (NUM_CH != 4) begin : g_bad_num_ch
        $error("dmc_channel_ctrl: NUM_CH must be 4");
    end

    function automatic logic [5:0] size_bytes(input logic [2:0] code);
        unique case (code)
            SZ_QUAD:  size_bytes = 6'h08;
            SZ_BYTE:  size_bytes = 6'h01;
            SZ_WORD:  size_bytes = 6'h02;
            SZ_LONG:  size_bytes = 6'h04;
            SZ_BLOCK: size_bytes = 6'h20;
            default:  size_bytes = 6'h00;
        endcase
    endfunction

    function automatic logic ext_allowed(input int ch, input logic odm);
        ext_allowed = (ch < 2) || (LATER_REV && odm); // RULE1 RULE2 RULE3
    endfunction

    function automatic logic is_timer_src(input logic [3:0] src);
        is_timer_src = (src == SRC_TMR_EE) || (src == SRC_TMR_EP) || (src == SRC_TMR_PE);
    endfunction

    dmc_state_t        s_reg;
    dmc_state_t        s_next;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [FMT_W-1:0]  fifo_data;

    dmc_fifo #(
        .WIDTH (FMT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fmt_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (fmt_valid),
        .in_ready  (fmt_ready),
        .in_data   (fmt_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign rdata       = s_reg.rdata;
    assign start_valid = s_reg.start_valid;
    assign start_desc  = s_reg.desc;

    always_comb begin
        logic [NUM_CH-1:0] ext_edge;
        logic [NUM_CH-1:0] req;
        logic [NUM_CH-1:0] clr;
        logic              found;
        logic [1:0]        gidx;
        logic [7:0]        c;
        logic              fmt_path;
        ext_edge = '0;
        req      = '0;
        clr      = '0;
        found    = 1'b0;
        gidx     = 2'h0;
        c        = 8'h00;
        fmt_path = 1'b0;
        fifo_pop = 1'b0;
        s_next   = s_reg;
        s_next.rdata = 32'h0000_0000;

        // request pins are asynchronous: two flops before anything looks
        s_next.ext_q1 = ~ext_req_n;
        s_next.ext_q2 = s_reg.ext_q1;
        s_next.ext_q3 = s_reg.ext_q2;
        ext_edge      = s_reg.ext_q2 & ~s_reg.ext_q3;

        if (wr) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (addr == OFF_CTRL0 + ADDR_W'(ch) * OFF_STRIDE) begin
                    s_next.ctrl[ch] = wdata[7:0];
                end
            end
            if (addr == OFF_GLOBAL) begin
                s_next.on_demand_transfer_mode = wdata[ODM_BIT];
            end
        end
        if (rd) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                if (addr == OFF_CTRL0 + ADDR_W'(ch) * OFF_STRIDE) begin
                    s_next.rdata = {24'h00_0000, s_reg.ctrl[ch]};
                end
            end
            if (addr == OFF_GLOBAL) begin
                s_next.rdata[ODM_BIT] = s_reg.on_demand_transfer_mode;
                // revision is fixed at build time, software can only read it
                s_next.rdata[REV_BIT] = LATER_REV;
            end
            if (addr == OFF_STATUS) begin
                s_next.rdata[3:0] = s_reg.pend_ext;
                s_next.rdata[7:4] = s_reg.pend_tmr;
                s_next.rdata[8]   = s_reg.start_valid;
                s_next.rdata[9]   = fifo_valid;
            end
        end

        // format word only drives channel zero in on-demand mode
        fmt_path = s_reg.on_demand_transfer_mode && fifo_valid; // RULE5
        for (int ch = 0; ch < NUM_CH; ch++) begin
            c = s_reg.ctrl[ch];
            // invalid size codes never start, so no width is left undefined
            req[ch] = chan_enable[ch] && global_enable
                      && (size_bytes(c[SIZE_HI:SIZE_LO]) != 6'h00) // RULE10
                      && (s_reg.pend_ext[ch] || s_reg.pend_tmr[ch]
                          || (ch == 0 && fmt_path));
        end
        // scan from the top so the lowest channel number wins
        for (int ch = NUM_CH - 1; ch >= 0; ch--) begin
            if (req[ch]) begin
                found = 1'b1;
                gidx  = 2'(ch);
            end
        end

        if (!s_reg.start_valid || start_ready) begin
            s_next.start_valid = found;
            if (found) begin
                c = s_reg.ctrl[gidx];
                s_next.desc.chan         = gidx;
                s_next.desc.bus_burst    = c[BUS_MODE_BIT]; // RULE6
                s_next.desc.size_code    = c[SIZE_HI:SIZE_LO]; // RULE7
                s_next.desc.access_bytes = size_bytes(c[SIZE_HI:SIZE_LO]); // RULE7 RULE8
                s_next.desc.dir          = 1'b0;
                s_next.desc.addr_mode    = AM_DUAL;
                s_next.desc.route        = ROUTE_EXT_EXT;
                s_next.desc.kind         = KIND_EXT;
                if (gidx == 2'h0 && fmt_path) begin
                    fifo_pop              = 1'b1;
                    s_next.desc.kind      = KIND_FMT;
                    s_next.desc.route     = ROUTE_FORMAT;
                    s_next.desc.dir       = fifo_data[FMT_DIR_BIT]; // RULE5
                    s_next.desc.addr_mode = LATER_REV ? fifo_data[FMT_MD_HI:FMT_MD_LO]
                                                      : AM_SINGLE; // RULE4
                end else if (s_reg.pend_ext[gidx]) begin
                    clr[gidx]          = 1'b1;
                    s_next.desc.kind   = KIND_EXT;
                end else begin
                    clr[gidx]        = 1'b1;
                    s_next.desc.kind = KIND_TMR;
                    // timer capture routes are all dual address
                    unique case (c[SRC_HI:SRC_LO]) // RULE9
                        SRC_TMR_EP: s_next.desc.route = ROUTE_EXT_PERIPH;
                        SRC_TMR_PE: s_next.desc.route = ROUTE_PERIPH_EXT;
                        default:    s_next.desc.route = ROUTE_EXT_EXT;
                    endcase
                    s_next.desc.addr_mode = AM_DUAL; // RULE9
                end
            end
        end

        // set after clear so an event landing on the grant cycle survives
        for (int ch = 0; ch < NUM_CH; ch++) begin
            c = s_reg.ctrl[ch];
            if (clr[ch] && s_reg.pend_ext[ch]) begin
                s_next.pend_ext[ch] = 1'b0;
            end else if (clr[ch]) begin
                s_next.pend_tmr[ch] = 1'b0;
            end
            // prohibited source codes simply raise nothing
            if (ext_edge[ch] && c[SRC_HI:SRC_LO] == SRC_EXT
                && ext_allowed(ch, s_reg.on_demand_transfer_mode)) begin // RULE1 RULE2 RULE3
                s_next.pend_ext[ch] = 1'b1;
            end
            if (timer_unit_capture && is_timer_src(c[SRC_HI:SRC_LO])) begin // RULE9
                s_next.pend_tmr[ch] = 1'b1;
            end
            // channel zero listens only to the format buffer in on-demand mode
            if (ch == 0 && s_reg.on_demand_transfer_mode) begin
                s_next.pend_ext[ch] = 1'b0;
                s_next.pend_tmr[ch] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg                         <= '0;
            s_reg.ctrl                    <= {NUM_CH{CTRL_RST}};
            s_reg.on_demand_transfer_mode <= ODM_RST;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // dmc_channel_ctrl

// [sim/dmc_channel_ctrl_sva.sv]
`timescale 1ns/1ps
module dmc_chk_sva
    import dmc_pkg::*;
#(
    parameter bit LATER_REV = 1'b1
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       wdata,
    input wire logic              wr,
    input wire logic              start_valid,
    input wire dmc_desc_t         start_desc
);
    localparam logic [5:0] BYTES [5] = '{6'h08, 6'h01, 6'h02, 6'h04, 6'h20};
    // shadow of the writes, so descriptors can be tied to what software set
    logic       odm_reg;
    logic [7:0] ctrl_reg [4];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            odm_reg <= 1'b0;
            ctrl_reg <= '{default: 8'h00};
        end else if (wr && addr == OFF_GLOBAL) begin
            odm_reg <= wdata[ODM_BIT];
        end else if (wr && addr[7:4] == 4'h0 && addr[1:0] == 2'h0) begin
            ctrl_reg[addr[3:2]] <= wdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_ext_normal: assert property (
        start_valid && start_desc.kind == KIND_EXT && !odm_reg |-> start_desc.chan < 2'd2)
        else $error("external request served on channel two or three in normal mode");
    a_ext_rev: assert property (
        start_valid && start_desc.kind == KIND_EXT && !LATER_REV |-> start_desc.chan < 2'd2)
        else $error("external request served on upper channel in original revision");
    a_fmt_single: assert property (
        start_valid && start_desc.kind == KIND_FMT && !LATER_REV |->
        start_desc.addr_mode == AM_SINGLE)
        else $error("format transfer not single address in original revision");
    a_fmt_chan: assert property (
        start_valid && start_desc.kind == KIND_FMT |->
        start_desc.chan == 2'd0 && start_desc.route == ROUTE_FORMAT)
        else $error("format transfer not on channel zero");
    a_bus_mode: assert property (
        start_valid |-> start_desc.bus_burst == ctrl_reg[start_desc.chan][BUS_MODE_BIT])
        else $error("bus mode differs from control bit");
    a_size_field: assert property (
        start_valid |-> start_desc.size_code == ctrl_reg[start_desc.chan][SIZE_HI:SIZE_LO])
        else $error("size code differs from size field");
    a_size_width: assert property (
        start_valid |-> start_desc.access_bytes == BYTES[start_desc.size_code])
        else $error("access width does not match size code");
    a_size_known: assert property (
        start_valid |-> start_desc.size_code <= SZ_BLOCK)
        else $error("transfer started with unused size code");
    a_tmr_dual: assert property (
        start_valid && start_desc.kind == KIND_TMR |->
        start_desc.addr_mode == AM_DUAL && start_desc.route != ROUTE_FORMAT)
        else $error("timer transfer not dual address");
endmodule // dmc_chk_sva

// [sim/dmc_far_side.sv]
`timescale 1ns/1ps
module dmc_far_side
    import dmc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      stall,
    input  wire logic      start_valid,
    output logic           start_ready,
    input  wire dmc_desc_t start_desc,
    output logic [3:0]     ext_req_n,
    output logic           timer_unit_capture
);
    dmc_desc_t got_q [$];
    initial begin
        ext_req_n = 4'hF;
        timer_unit_capture = 1'b0;
    end
    assign start_ready = !stall;
    always @(posedge clk) begin
        if (start_valid && start_ready) begin
            got_q.push_back(start_desc);
        end
    end
    // held low well past the two-flop synchroniser
    task automatic pulse_ext(input int ch);
        @(posedge clk);
        ext_req_n[ch] <= 1'b0;
        repeat (4) @(posedge clk);
        ext_req_n[ch] <= 1'b1;
    endtask
    task automatic pulse_tmr();
        @(posedge clk);
        timer_unit_capture <= 1'b1;
        @(posedge clk);
        timer_unit_capture <= 1'b0;
    endtask
endmodule // dmc_far_side

// [sim/tb_dmc_channel_ctrl.sv]
`timescale 1ns/1ps
module tb_dmc_channel_ctrl;
    import dmc_pkg::*;
    localparam logic [5:0] BYTES [5] = '{6'h08, 6'h01, 6'h02, 6'h04, 6'h20};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [3:0]  ext_req_n;
    logic        timer_unit_capture;
    logic [3:0]  chan_enable = 4'hF;
    logic        global_enable = 1'b1;
    logic        fmt_valid = 1'b0;
    logic        fmt_ready;
    logic [63:0] fmt_data = 64'h0;
    logic        start_valid;
    logic        start_ready;
    dmc_desc_t   start_desc;
    logic        stall = 1'b0;
    int          error_cnt = 0;
    int          num_checks = 0;
    logic [31:0] v;
    int          acc;
    logic [31:0] v_o;
    logic [31:0] rdata_o;
    logic        start_valid_o;
    dmc_desc_t   start_desc_o;
    int          orig_fmt = 0;
    int          orig_hi = 0;
    logic [1:0]  orig_am = 2'h3;
    always #25 clk = ~clk;
    dmc_channel_ctrl i_dmc_channel_ctrl (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_req_n(ext_req_n),
        .timer_unit_capture(timer_unit_capture), .chan_enable(chan_enable),
        .global_enable(global_enable), .fmt_valid(fmt_valid), .fmt_ready(fmt_ready),
        .fmt_data(fmt_data), .start_valid(start_valid), .start_ready(start_ready),
        .start_desc(start_desc));
    dmc_far_side i_dmc_far_side (.clk(clk), .stall(stall), .start_valid(start_valid),
        .start_ready(start_ready), .start_desc(start_desc), .ext_req_n(ext_req_n),
        .timer_unit_capture(timer_unit_capture));
    // original revision beside the later one: same stimulus, never stalled
    dmc_channel_ctrl #(.LATER_REV(1'b0)) i_dmc_channel_ctrl_orig (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_o), .ext_req_n(ext_req_n),
        .timer_unit_capture(timer_unit_capture), .chan_enable(chan_enable),
        .global_enable(global_enable), .fmt_valid(fmt_valid), .fmt_ready(),
        .fmt_data(fmt_data), .start_valid(start_valid_o), .start_ready(1'b1),
        .start_desc(start_desc_o));
    always @(posedge clk) begin
        if (start_valid_o && start_desc_o.kind == KIND_FMT) begin
            orig_fmt <= orig_fmt + 1;
            orig_am  <= start_desc_o.addr_mode;
        end
        if (start_valid_o && start_desc_o.kind == KIND_EXT && start_desc_o.chan > 2'd1) begin
            orig_hi <= orig_hi + 1;
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        v_o = rdata_o;
    endtask
    // m selects how many fields the source fixes: 0 base, 1 plus route, 2 plus direction
    task automatic see(input dmc_desc_t e, input int m);
        dmc_desc_t g;
        for (int i = 0; i < 40 && i_dmc_far_side.got_q.size() == 0; i++) @(posedge clk);
        if (i_dmc_far_side.got_q.size() > 0) g = i_dmc_far_side.got_q.pop_front();
        chk({g.chan, g.kind, g.bus_burst, g.size_code, g.access_bytes},
            {e.chan, e.kind, e.bus_burst, e.size_code, e.access_bytes});
        if (m > 0) chk({g.route, g.addr_mode}, {e.route, e.addr_mode});
        if (m > 1) chk(g.dir, e.dir);
    endtask
    function automatic logic [63:0] fw(input int k);
        fw = 64'h0;
        fw[FMT_DIR_BIT] = k[0];
        fw[FMT_MD_HI:FMT_MD_LO] = {1'b0, ~k[0]};
    endfunction
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd_reg(OFF_CTRL0);
        chk(v, 32'h0000_0000);
        rd_reg(OFF_GLOBAL);
        chk(v, 32'h0000_0001);
        chk(v_o, 32'h0000_0000);
        rd_reg(8'h20);
        chk(v, 32'h0000_0000);
        for (int s = 0; s < 5; s++) begin
            wr_reg(OFF_STRIDE, {24'h0, s[0], s[2:0], SRC_EXT});
            rd_reg(OFF_STRIDE);
            chk(v, {24'h0, s[0], s[2:0], SRC_EXT});
            i_dmc_far_side.pulse_ext(1);
            see('{2'd1, KIND_EXT, ROUTE_EXT_EXT, 1'b0, AM_DUAL, s[0], s[2:0], BYTES[s]}, 0);
        end
        // unused size code must not start the channel
        wr_reg(OFF_STRIDE, {24'h0, 1'b0, 3'h5, SRC_EXT});
        i_dmc_far_side.pulse_ext(1);
        wr_reg(8'h08, {24'h0, 1'b0, SZ_LONG, SRC_EXT});
        i_dmc_far_side.pulse_ext(2);
        repeat (15) @(posedge clk);
        chk(i_dmc_far_side.got_q.size(), 0);
        wr_reg(OFF_GLOBAL, 32'h0000_8000);
        i_dmc_far_side.pulse_ext(2);
        see('{2'd2, KIND_EXT, ROUTE_EXT_EXT, 1'b0, AM_DUAL, 1'b0, SZ_LONG, 6'h04}, 0);
        // consumer stalls: one word sits in the output, four fill the buffer
        stall <= 1'b1;
        acc = 0;
        fmt_valid <= 1'b1;
        fmt_data <= fw(0);
        repeat (12) begin
            @(posedge clk);
            if (fmt_ready) begin
                acc++;
                fmt_data <= fw(acc);
            end
        end
        fmt_valid <= 1'b0;
        chk(acc, 5);
        chk(fmt_ready, 1'b0);
        stall <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            see('{2'd0, KIND_FMT, ROUTE_FORMAT, k[0], {1'b0, ~k[0]}, 1'b0, SZ_QUAD, 6'h08}, 2);
        end
        rd_reg(OFF_STATUS);
        chk(v[9], 1'b0);
        chk(orig_fmt > 0, 1'b1);
        chk(orig_am, AM_SINGLE);
        chk(orig_hi, 0);
        wr_reg(OFF_GLOBAL, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'h0C, {24'h0, 1'b1, SZ_WORD, SRC_TMR_EE + 4'(k)});
            // first capture lands while globally disabled: it must wait, not vanish
            global_enable <= (k != 0);
            i_dmc_far_side.pulse_tmr();
            if (k == 0) begin
                repeat (5) @(posedge clk);
                chk(i_dmc_far_side.got_q.size(), 0);
                global_enable <= 1'b1;
            end
            see('{2'd3, KIND_TMR, dmc_route_t'(k), 1'b0, AM_DUAL, 1'b1, SZ_WORD, 6'h02}, 1);
        end
        wrap_up();
    end
    initial begin
        #200_000;
        error_cnt++;
        wrap_up();
    end
endmodule // tb_dmc_channel_ctrl
bind dmc_channel_ctrl dmc_chk_sva #(.LATER_REV(LATER_REV)) i_dmc_chk_sva (.clk(clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .start_valid(start_valid),
    .start_desc(start_desc));
